// File: hw/rxfs_pkg.sv
package rxfs_pkg;

    // register byte offsets on the apb window
    localparam logic [7:0] STATUS_OFS  = 8'h00;
    localparam logic [7:0] ENABLE_OFS  = 8'h04;
    localparam logic [7:0] COMMAND_OFS = 8'h08;

    // status / enable bit positions
    localparam int RX_INTR_BIT  = 0;
    localparam int CRC_BIT      = 1;
    localparam int OVF_BIT      = 2;
    localparam int LONG_BIT     = 3;
    localparam int GOOD_BIT     = 4;
    localparam int ALIGN_BIT    = 5;
    localparam int RUNT_BIT     = 6;

    // command register bit positions
    localparam int ACC_RUNT_BIT = 0;
    localparam int ACC_LONG_BIT = 1;
    localparam int ACC_CRC_BIT  = 2;

    // frame length limits in bytes
    localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
    localparam logic [15:0] MAX_FRAME_BYTES = 16'h05ee;

    // reset values
    localparam logic [6:0] STATUS_RST  = 7'h00;
    localparam logic [6:0] ENABLE_RST  = 7'h00;
    localparam logic [2:0] COMMAND_RST = 3'h0;

    typedef struct packed {
        logic        done;
        logic [15:0] len_bytes;
        logic        odd_bits;
        logic        crc_bad;
    } rxfs_frame_t;

    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } rxfs_apb_req_t;

endpackage

// File: hw/rxfs_top.sv
`timescale 1ns/1ps
module rxfs_top (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // receive path events, same clock domain
    input  wire logic        FRAME_DONE,
    input  wire logic [15:0] FRAME_LEN,
    input  wire logic        FRAME_ODD_BITS,
    input  wire logic        FRAME_CRC_BAD,
    input  wire logic        FIFO_OVERFLOW,
    input  wire logic        FRAME_ACTIVE,
    // results
    output logic             FRAME_DELIVER,
    output logic             FRAME_DISCARD,
    output logic             RX_INTERRUPT
);

    rxfs_pkg::rxfs_frame_t   frm;
    rxfs_pkg::rxfs_apb_req_t req;

    logic [6:0] status_q;
    logic [6:0] status_d;
    logic [6:0] enable_q;
    logic [2:0] command_q;
    logic [6:0] set_ev;
    logic [6:0] clr_ev;
    logic       ovf_seen_q;
    logic       acc_access;
    logic       wr_access;
    logic       is_runt;
    logic       is_long;
    logic       drop;
    logic       irq_d;

    assign frm = '{done: FRAME_DONE, len_bytes: FRAME_LEN,
                   odd_bits: FRAME_ODD_BITS, crc_bad: FRAME_CRC_BAD};
    assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE,
                   addr: PADDR, wdata: PWDATA};

    // registered pready: every access phase takes exactly two cycles
    assign acc_access = req.sel && req.enable && PREADY;
    assign wr_access  = acc_access && req.write;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    // frame classification
    assign is_runt = frm.len_bytes < rxfs_pkg::MIN_FRAME_BYTES;
    assign is_long = frm.len_bytes > rxfs_pkg::MAX_FRAME_BYTES;

    // overflow during the frame marks it for discard until it ends
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ovf_seen_q <= 1'b0;
        end else if (frm.done) begin
            ovf_seen_q <= 1'b0;
        end else if (FIFO_OVERFLOW && FRAME_ACTIVE) begin
            ovf_seen_q <= 1'b1;
        end
    end

    always_comb begin
        set_ev = 7'h00;
        if (frm.done) begin
            set_ev[rxfs_pkg::RUNT_BIT]  = is_runt && !command_q[rxfs_pkg::ACC_RUNT_BIT];
            set_ev[rxfs_pkg::LONG_BIT]  = is_long && !command_q[rxfs_pkg::ACC_LONG_BIT];
            set_ev[rxfs_pkg::CRC_BIT]   = frm.crc_bad && !command_q[rxfs_pkg::ACC_CRC_BIT];
            set_ev[rxfs_pkg::ALIGN_BIT] = frm.odd_bits;
            set_ev[rxfs_pkg::GOOD_BIT]  = 1'b1;
        end
        set_ev[rxfs_pkg::OVF_BIT] = FIFO_OVERFLOW && FRAME_ACTIVE;
    end

    // a frame is dropped by an unaccepted runt, long or crc error or an overflow inside it; an align error alone does not drop it
    assign drop = set_ev[rxfs_pkg::RUNT_BIT] || set_ev[rxfs_pkg::LONG_BIT]
                || set_ev[rxfs_pkg::CRC_BIT] || ovf_seen_q
                || (FIFO_OVERFLOW && FRAME_ACTIVE);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FRAME_DELIVER <= 1'b0;
            FRAME_DISCARD <= 1'b0;
        end else begin
            FRAME_DELIVER <= frm.done && !drop;
            FRAME_DISCARD <= frm.done && drop;
        end
    end

    // write one clears; bit 0 is derived and not stored
    assign clr_ev = (wr_access && addr_hit(req.addr, rxfs_pkg::STATUS_OFS))
                  ? {req.wdata[6:1], 1'b0} : 7'h00;

    // set wins over a clear landing in the same cycle
    assign status_d = (status_q & ~clr_ev) | {set_ev[6:1], 1'b0};

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            status_q <= rxfs_pkg::STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            enable_q  <= rxfs_pkg::ENABLE_RST;
            command_q <= rxfs_pkg::COMMAND_RST;
        end else if (wr_access) begin
            if (addr_hit(req.addr, rxfs_pkg::ENABLE_OFS)) begin
                enable_q <= req.wdata[6:0];
            end
            if (addr_hit(req.addr, rxfs_pkg::COMMAND_OFS)) begin
                command_q <= req.wdata[2:0];
            end
        end
    end

    // interrupt follows next state so it tracks the flags with one register
    assign irq_d = |(status_d[6:1] & enable_q[6:1]);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            RX_INTERRUPT <= 1'b0;
        end else begin
            RX_INTERRUPT <= irq_d;
        end
    end

    // apb: one wait state, pready pulses in the second access cycle
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= req.sel && req.enable && !PREADY;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            if (req.sel && req.enable && !PREADY) begin
                PSLVERR <= !(addr_hit(req.addr, rxfs_pkg::STATUS_OFS)
                          || addr_hit(req.addr, rxfs_pkg::ENABLE_OFS)
                          || addr_hit(req.addr, rxfs_pkg::COMMAND_OFS));
                if (!req.write) begin
                    case (1'b1)
                        addr_hit(req.addr, rxfs_pkg::STATUS_OFS): begin
                            PRDATA <= {25'h0, status_d[6:1], irq_d};
                        end
                        addr_hit(req.addr, rxfs_pkg::ENABLE_OFS): begin
                            PRDATA <= {25'h0, enable_q};
                        end
                        addr_hit(req.addr, rxfs_pkg::COMMAND_OFS): begin
                            PRDATA <= {29'h0, command_q};
                        end
                        default: begin
                            PRDATA <= 32'h0000_0000;
                        end
                    endcase
                end
            end
        end
    end

    // checks
    property p_runt_set;
        @(posedge CLK) disable iff (RESET)
        (frm.done && is_runt && !command_q[rxfs_pkg::ACC_RUNT_BIT])
            |=> status_q[rxfs_pkg::RUNT_BIT];
    endproperty
    a_runt_set: assert property (p_runt_set) else $error("runt flag not set");

    property p_runt_accept;
        @(posedge CLK) disable iff (RESET)
        (frm.done && is_runt && command_q[rxfs_pkg::ACC_RUNT_BIT] && !frm.crc_bad
         && !frm.odd_bits && !FIFO_OVERFLOW && !ovf_seen_q) |=> FRAME_DELIVER;
    endproperty
    a_runt_accept: assert property (p_runt_accept) else $error("accepted runt not delivered");

    property p_long_drop;
        @(posedge CLK) disable iff (RESET)
        (frm.done && is_long && !command_q[rxfs_pkg::ACC_LONG_BIT])
            |=> (FRAME_DISCARD && status_q[rxfs_pkg::LONG_BIT]);
    endproperty
    a_long_drop: assert property (p_long_drop) else $error("long frame not dropped");

    property p_crc_drop;
        @(posedge CLK) disable iff (RESET)
        (frm.done && frm.crc_bad && !command_q[rxfs_pkg::ACC_CRC_BIT])
            |=> (FRAME_DISCARD && !FRAME_DELIVER && status_q[rxfs_pkg::CRC_BIT]);
    endproperty
    a_crc_drop: assert property (p_crc_drop) else $error("crc frame not dropped");

    // an overflow mid-frame is remembered until the frame ends
    property p_ovf_mark;
        @(posedge CLK) disable iff (RESET)
        (FIFO_OVERFLOW && FRAME_ACTIVE && !frm.done) |=> ovf_seen_q;
    endproperty
    a_ovf_mark: assert property (p_ovf_mark) else $error("overflow not remembered");

    property p_ovf_hold;
        @(posedge CLK) disable iff (RESET)
        (ovf_seen_q && !frm.done) |=> ovf_seen_q;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow mark lost");

    property p_ovf_discard;
        @(posedge CLK) disable iff (RESET)
        (frm.done && (ovf_seen_q || (FIFO_OVERFLOW && FRAME_ACTIVE)))
            |=> (FRAME_DISCARD && !FRAME_DELIVER);
    endproperty
    a_ovf_discard: assert property (p_ovf_discard) else $error("overflowed frame kept");

    property p_ovf_flag;
        @(posedge CLK) disable iff (RESET)
        (FIFO_OVERFLOW && FRAME_ACTIVE) |=> status_q[rxfs_pkg::OVF_BIT];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

    property p_good_set;
        @(posedge CLK) disable iff (RESET)
        frm.done |=> status_q[rxfs_pkg::GOOD_BIT];
    endproperty
    a_good_set: assert property (p_good_set) else $error("good flag not set");

    // an enable write reaches the pin one cycle late, so that edge is skipped
    property p_irq_or;
        @(posedge CLK) disable iff (RESET)
        $stable(enable_q) |-> (RX_INTERRUPT == |(status_q[6:1] & enable_q[6:1]));
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("interrupt not or of flags");

    property p_sticky;
        @(posedge CLK) disable iff (RESET)
        (status_q[rxfs_pkg::ALIGN_BIT] && !clr_ev[rxfs_pkg::ALIGN_BIT])
            |=> status_q[rxfs_pkg::ALIGN_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without clear");

    property p_set_wins;
        @(posedge CLK) disable iff (RESET)
        (set_ev[rxfs_pkg::OVF_BIT] && clr_ev[rxfs_pkg::OVF_BIT]) |=> status_q[rxfs_pkg::OVF_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat set");

    property p_clear;
        @(posedge CLK) disable iff (RESET)
        (clr_ev[rxfs_pkg::RUNT_BIT] && !set_ev[rxfs_pkg::RUNT_BIT])
            |=> !status_q[rxfs_pkg::RUNT_BIT];
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear");

    property p_align_set;
        @(posedge CLK) disable iff (RESET)
        (frm.done && frm.odd_bits) |=> status_q[rxfs_pkg::ALIGN_BIT];
    endproperty
    a_align_set: assert property (p_align_set) else $error("align flag not set");

    property p_runt_quiet;
        @(posedge CLK) disable iff (RESET)
        (frm.done && is_runt && command_q[rxfs_pkg::ACC_RUNT_BIT]
         && !status_q[rxfs_pkg::RUNT_BIT]) |=> !status_q[rxfs_pkg::RUNT_BIT];
    endproperty
    a_runt_quiet: assert property (p_runt_quiet) else $error("runt flag raised");

    property p_long_accept;
        @(posedge CLK) disable iff (RESET)
        (frm.done && is_long && command_q[rxfs_pkg::ACC_LONG_BIT] && !frm.crc_bad
         && !ovf_seen_q && !(FIFO_OVERFLOW && FRAME_ACTIVE)) |=> FRAME_DELIVER;
    endproperty
    a_long_accept: assert property (p_long_accept) else $error("long frame dropped");

    property p_long_quiet;
        @(posedge CLK) disable iff (RESET)
        (frm.done && is_long && command_q[rxfs_pkg::ACC_LONG_BIT]
         && !status_q[rxfs_pkg::LONG_BIT]) |=> !status_q[rxfs_pkg::LONG_BIT];
    endproperty
    a_long_quiet: assert property (p_long_quiet) else $error("long flag raised");

    property p_crc_accept;
        @(posedge CLK) disable iff (RESET)
        (frm.done && frm.crc_bad && command_q[rxfs_pkg::ACC_CRC_BIT] && !is_runt && !is_long
         && !ovf_seen_q && !(FIFO_OVERFLOW && FRAME_ACTIVE)) |=> FRAME_DELIVER;
    endproperty
    a_crc_accept: assert property (p_crc_accept) else $error("crc frame dropped");

    property p_crc_quiet;
        @(posedge CLK) disable iff (RESET)
        (frm.done && frm.crc_bad && command_q[rxfs_pkg::ACC_CRC_BIT]
         && !status_q[rxfs_pkg::CRC_BIT]) |=> !status_q[rxfs_pkg::CRC_BIT];
    endproperty
    a_crc_quiet: assert property (p_crc_quiet) else $error("crc flag raised");

    property p_good_clear;
        @(posedge CLK) disable iff (RESET)
        (clr_ev[rxfs_pkg::GOOD_BIT] && !set_ev[rxfs_pkg::GOOD_BIT])
            |=> !status_q[rxfs_pkg::GOOD_BIT];
    endproperty
    a_good_clear: assert property (p_good_clear) else $error("good flag kept");

    property p_align_clear;
        @(posedge CLK) disable iff (RESET)
        (clr_ev[rxfs_pkg::ALIGN_BIT] && !set_ev[rxfs_pkg::ALIGN_BIT])
            |=> !status_q[rxfs_pkg::ALIGN_BIT];
    endproperty
    a_align_clear: assert property (p_align_clear) else $error("align flag kept");

    property p_long_clear;
        @(posedge CLK) disable iff (RESET)
        (clr_ev[rxfs_pkg::LONG_BIT] && !set_ev[rxfs_pkg::LONG_BIT])
            |=> !status_q[rxfs_pkg::LONG_BIT];
    endproperty
    a_long_clear: assert property (p_long_clear) else $error("long flag kept");

    property p_crc_clear;
        @(posedge CLK) disable iff (RESET)
        (clr_ev[rxfs_pkg::CRC_BIT] && !set_ev[rxfs_pkg::CRC_BIT])
            |=> !status_q[rxfs_pkg::CRC_BIT];
    endproperty
    a_crc_clear: assert property (p_crc_clear) else $error("crc flag kept");

endmodule // rxfs_top

// File: bench/rxfs_net_model.sv
`timescale 1ns/1ps
module rxfs_net_model (
    // clock
    input  wire logic        clk,
    // receive path toward the mac
    output logic             frame_done,
    output logic [15:0]      frame_len,
    output logic             frame_odd_bits,
    output logic             frame_crc_bad,
    output logic             fifo_overflow,
    output logic             frame_active
);
    initial begin
        frame_done     = 1'b0;
        frame_len      = 16'h0000;
        frame_odd_bits = 1'b0;
        frame_crc_bad  = 1'b0;
        fifo_overflow  = 1'b0;
        frame_active   = 1'b0;
    end

    // overflow only counts inside a frame, so it is raised mid-frame
    task automatic send(input logic [15:0] l, input logic o, c, v);
        @(posedge clk);
        frame_active <= 1'b1;
        @(posedge clk);
        // one overflow per frame at most: software tuning keeps them rare
        fifo_overflow <= v;
        @(posedge clk);
        fifo_overflow  <= 1'b0;
        frame_done     <= 1'b1;
        frame_len      <= l;
        frame_odd_bits <= o;
        frame_crc_bad  <= c;
        @(posedge clk);
        // stale qualifiers are inverted so nothing leans on held values
        frame_done     <= 1'b0;
        frame_active   <= 1'b0;
        frame_len      <= ~l;
        frame_odd_bits <= ~o;
        frame_crc_bad  <= ~c;
    endtask
endmodule // rxfs_net_model

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        done, odd, crc, ovf, act, dlv, dsc, irq;
    logic [7:0]  paddr, ex;
    logic [31:0] pwdata, prdata, rd, m;
    logic [15:0] len;
    logic [15:0] lens [8] = '{16'h003f, 16'h0040, 16'h05ee, 16'h05ef,
                              16'h0001, 16'hffff, 16'h0100, 16'h05ed};
    logic [6:0]  fl, en;
    logic [2:0]  cmd;
    int          checks, failures, seed, cyc;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    rxfs_top u_dut (.CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .FRAME_DONE(done), .FRAME_LEN(len),
        .FRAME_ODD_BITS(odd), .FRAME_CRC_BAD(crc), .FIFO_OVERFLOW(ovf),
        .FRAME_ACTIVE(act), .FRAME_DELIVER(dlv), .FRAME_DISCARD(dsc),
        .RX_INTERRUPT(irq));

    rxfs_net_model u_net (.clk(clk), .frame_done(done), .frame_len(len),
        .frame_odd_bits(odd), .frame_crc_bad(crc), .fifo_overflow(ovf),
        .frame_active(act));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end

    // the request stands until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] predict(input logic [15:0] l, input logic o, c, v,
                                           input logic [2:0] k);
        logic [6:0] f;
        f = 7'h00;
        f[rxfs_pkg::GOOD_BIT]  = 1'b1;
        f[rxfs_pkg::ALIGN_BIT] = o;
        f[rxfs_pkg::OVF_BIT]   = v;
        f[rxfs_pkg::RUNT_BIT]  = l < rxfs_pkg::MIN_FRAME_BYTES && !k[rxfs_pkg::ACC_RUNT_BIT];
        f[rxfs_pkg::LONG_BIT]  = l > rxfs_pkg::MAX_FRAME_BYTES && !k[rxfs_pkg::ACC_LONG_BIT];
        f[rxfs_pkg::CRC_BIT]   = c && !k[rxfs_pkg::ACC_CRC_BIT];
        return {f[6] | f[3] | f[2] | f[1], f};
    endfunction

    task automatic rd_st;
        apb(1'b0, rxfs_pkg::STATUS_OFS, 32'h0);
        chk("status", {25'h0, fl[6:1], |(fl[6:1] & en[6:1])}, rd);
        chk("rx_interrupt", {31'h0, |(fl[6:1] & en[6:1])}, {31'h0, irq});
    endtask

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = 32'h6d2d;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset_value", 32'h0, rd);
        end
        apb(1'b1, 8'h0c, 32'hffffffff);
        chk("unmapped_err", 32'h1, {31'h0, err});
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped_rd", 32'h0, rd);
        for (int i = 0; i < 40; i++) begin
            cmd = 3'($random(seed));
            en  = 7'($random(seed));
            m   = $random(seed);
            len = (i < 8) ? lens[i] : 16'(16'h0020 + {$random(seed)} % 1600);
            apb(1'b1, rxfs_pkg::COMMAND_OFS, {29'h0, cmd});
            apb(1'b1, rxfs_pkg::ENABLE_OFS, {25'h0, en});
            apb(1'b0, rxfs_pkg::ENABLE_OFS, 32'h0);
            chk("enable", {25'h0, en}, rd);
            apb(1'b1, rxfs_pkg::STATUS_OFS, 32'h7e);
            ex = predict(len, m[8], m[9], m[11:10] == 2'b00, cmd);
            u_net.send(len, m[8], m[9], m[11:10] == 2'b00);
            @(negedge clk);
            chk("deliver", {31'h0, !ex[7]}, {31'h0, dlv});
            chk("discard", {31'h0, ex[7]}, {31'h0, dsc});
            fl = ex[6:0];
            rd_st();
            // random mask: zero bits must leave their flags alone
            apb(1'b1, rxfs_pkg::STATUS_OFS, m);
            fl = fl & ~m[6:0];
            fl[0] = 1'b0;
            rd_st();
        end
        // a clear landing on the overflow cycle must lose to the set
        apb(1'b1, rxfs_pkg::STATUS_OFS, 32'h7e);
        fork
            apb(1'b1, rxfs_pkg::STATUS_OFS, 32'h04);
            begin
                @(posedge clk);
                u_net.send(16'h0100, 1'b0, 1'b0, 1'b1);
            end
        join
        ex = predict(16'h0100, 1'b0, 1'b0, 1'b1, cmd);
        @(negedge clk);
        chk("discard", 32'h1, {31'h0, dsc});
        fl = ex[6:0];
        rd_st();
        wrap_up();
    end
endmodule // testbench
